// ---- trst_pkg.sv ----
// package for the transfer request stage tracker: register map,
// field positions, depth codes and the bus carrier types.
// assumes a 32-bit apb slave and a same-clock upstream controller.

`default_nettype none

package trst_pkg;

    ////////////////////////////////////////////////////////////////////
    // widths
    localparam int TR_W = 32;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int PTR_W = 2;
    localparam int OCC_W = 3;
    localparam int WACK_W = 4;
    localparam int FIFO_ENTRIES = 4;

    ////////////////////////////////////////////////////////////////////
    // register offsets (byte addresses)
    localparam logic [ADDR_W-1:0] STATUS_OFF = 12'h000;
    localparam logic [ADDR_W-1:0] CONFIG_OFF = 12'h004;
    localparam logic [ADDR_W-1:0] CONTROL_OFF = 12'h008;

    // status fields
    localparam int PROG_BIT = 0;
    localparam int SRC_BIT = 1;
    localparam int WACK_BIT = 2;
    localparam int OCC_LSB = 4;
    localparam int OCC_MSB = 6;
    localparam int HEAD_LSB = 11;
    localparam int HEAD_MSB = 12;
    // config and control fields
    localparam int DEPTH_LSB = 8;
    localparam int DEPTH_MSB = 9;
    localparam int HOLD_BIT = 0;

    ////////////////////////////////////////////////////////////////////
    // destination depth codes and occupancy values
    localparam logic [1:0] DEPTH_CODE_1 = 2'h0;
    localparam logic [1:0] DEPTH_CODE_2 = 2'h1;
    localparam logic [1:0] DEPTH_CODE_4 = 2'h2;
    localparam logic [1:0] DEST_DEPTH_CFG = DEPTH_CODE_4;
    localparam logic [OCC_W-1:0] OCC_EMPTY = 3'h0;
    localparam logic [OCC_W-1:0] OCC_ONE = 3'h1;
    localparam logic [OCC_W-1:0] OCC_TWO = 3'h2;
    localparam logic [OCC_W-1:0] OCC_FOUR = 3'h4;
    localparam logic [WACK_W-1:0] WACK_ZERO = 4'h0;
    localparam logic [WACK_W-1:0] WACK_ONE = 4'h1;
    localparam logic [WACK_W-1:0] WACK_MAX = 4'hf;

    function automatic logic [OCC_W-1:0] depth_entries(
        input logic [1:0] code);
        case (code)
            DEPTH_CODE_1: depth_entries = OCC_ONE;
            DEPTH_CODE_2: depth_entries = OCC_TWO;
            default: depth_entries = OCC_FOUR;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [DATA_W-1:0] pwdata;
    } trst_apb_req_type;

    typedef struct packed {
        logic [DATA_W-1:0] prdata;
        logic pready;
        logic pslverr;
    } trst_apb_rsp_type;

    typedef enum logic {
        PROG_IDLE = 1'b0,
        PROG_BUSY = 1'b1
    } trst_prog_state_type;

endpackage

`default_nettype wire

// ---- trst_dest_mem.sv ----
// storage for the destination register fifo entries.
// assumes one write and one read per cycle; read data registered.

`timescale 1ns/1ps
`default_nettype none

module trst_dest_mem (
    input wire logic clk,
    input wire logic reset,
    input wire logic we,
    input wire logic [trst_pkg::PTR_W-1:0] waddr,
    input wire logic [trst_pkg::TR_W-1:0] wdata,
    input wire logic [trst_pkg::PTR_W-1:0] raddr,
    output logic [trst_pkg::TR_W-1:0] rdata
);
    import trst_pkg::*;

    logic [TR_W-1:0] mem_q [FIFO_ENTRIES];

    always_ff @(posedge clk) begin
        if (we) begin
            mem_q[waddr] <= wdata;
        end
    end

    // write-first so a push into an empty fifo shows at the head at once
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rdata <= '0;
        end else if (we && (waddr == raddr)) begin
            rdata <= wdata;
        end else begin
            rdata <= mem_q[raddr];
        end
    end
endmodule

`default_nettype wire

// ---- trst_src_stage.sv ----
// source-active register set: one transfer request being read.
// assumes load only while idle or on the cycle it goes idle.

`timescale 1ns/1ps
`default_nettype none

module trst_src_stage (
    input wire logic clk,
    input wire logic reset,
    input wire logic load,
    input wire logic [trst_pkg::TR_W-1:0] load_data,
    input wire logic done,
    output logic active,
    output logic [trst_pkg::TR_W-1:0] data
);
    import trst_pkg::*;

    // a load in the done cycle wins, so no request slips by
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            active <= 1'b0;
        end else if (load) begin
            active <= 1'b1;
        end else if (done) begin
            active <= 1'b0;
        end
    end

    // contents stay after going idle, handy for debug
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            data <= '0;
        end else if (load) begin
            data <= load_data;
        end
    end
endmodule

`default_nettype wire

// ---- trst_tracker.sv ----
// transfer request stage tracker: programming stage, source stage,
// destination fifo and the status/config/control registers on apb.
// assumes every input comes from logic on clk; no pins are sampled.
//
// The APB register port and the register offsets were chosen for this implementation.

`timescale 1ns/1ps
`default_nettype none

// Contract
// - occupancy field gives requests held in destination fifo, 0h-4h only.
// - with depth four, occupancy 4h means the destination fifo is full.
// - programmed request enters an empty destination fifo at once unless the control hold bit is set.
// - partly filled fifo takes the request at once only if source idle.
// - a full destination fifo accepts no further request.
// - full ends only when the head request completes and frees an entry.
// - status bit 2 is one while any write status is still owed.
// - status bit 1 is one while the source stage serves a request.
// - an idle source stage keeps its last request's contents.
// - status bit 0 is one while the programming stage holds a request.
// - occupancy sits in status bits 6 to 4, zero meaning empty.
// - config bits 9 to 8 give the fixed destination depth code.
module trst_tracker (
    input wire logic clk,
    input wire logic reset,
    input wire trst_pkg::trst_apb_req_type apb_req,
    output trst_pkg::trst_apb_rsp_type apb_rsp,
    input wire logic tr_load_valid,
    input wire logic [trst_pkg::TR_W-1:0] tr_load_data,
    input wire logic src_done,
    input wire logic dst_done,
    input wire logic wr_cmd_issue,
    input wire logic wr_status_ret,
    output logic program_stage_busy,
    output logic source_stage_active,
    output logic write_ack_pending,
    output logic [trst_pkg::OCC_W-1:0] dest_fifo_occupancy,
    output logic [trst_pkg::TR_W-1:0] src_tr_data,
    output logic [trst_pkg::TR_W-1:0] dest_head_data,
    output logic dest_head_valid
);
    import trst_pkg::*;

    trst_prog_state_type prog_q;
    logic [TR_W-1:0] prog_data_q;
    logic hold_q;
    logic [OCC_W-1:0] occ_q;
    logic [OCC_W-1:0] occ_d;
    logic [PTR_W-1:0] wr_ptr_q;
    logic [PTR_W-1:0] rd_ptr_q;
    logic [PTR_W-1:0] rd_ptr_d;
    logic [WACK_W-1:0] wack_q;
    logic [OCC_W-1:0] dest_fifo_depth_cfg;
    logic fifo_empty;
    logic fifo_full;
    logic move;
    logic pop;
    logic [DATA_W-1:0] status_word;
    logic [DATA_W-1:0] config_word;
    logic [DATA_W-1:0] control_word;
    logic access;
    logic done_edge;
    logic mapped;

    ////////////////////////////////////////////////////////////////////
    // destination fifo state

    assign dest_fifo_depth_cfg = depth_entries(DEST_DEPTH_CFG);
    assign fifo_empty = (occ_q == OCC_EMPTY);
    assign fifo_full = (occ_q == dest_fifo_depth_cfg);

    // empty: go now; partial: only with source idle; full: blocked
    assign move = (prog_q == PROG_BUSY) && !hold_q && !fifo_full
        && (fifo_empty || !source_stage_active);

    // only a completed head request frees an entry
    assign pop = dst_done && !fifo_empty;

    always_comb begin
        occ_d = occ_q;
        rd_ptr_d = rd_ptr_q;
        if (move && !pop) begin
            occ_d = occ_q + OCC_ONE;
        end else if (pop && !move) begin
            occ_d = occ_q - OCC_ONE;
        end
        if (pop) begin
            rd_ptr_d = rd_ptr_q + 2'h1;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            occ_q <= OCC_EMPTY;
        end else begin
            occ_q <= occ_d;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
        end else begin
            rd_ptr_q <= rd_ptr_d;
            if (move) begin
                wr_ptr_q <= wr_ptr_q + 2'h1;
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            dest_head_valid <= 1'b0;
            dest_fifo_occupancy <= OCC_EMPTY;
        end else begin
            dest_head_valid <= (occ_d != OCC_EMPTY);
            dest_fifo_occupancy <= occ_d;
        end
    end

    trst_dest_mem u_mem (
        .clk(clk),
        .reset(reset),
        .we(move),
        .waddr(wr_ptr_q),
        .wdata(prog_data_q),
        .raddr(rd_ptr_d),
        .rdata(dest_head_data)
    );

    ////////////////////////////////////////////////////////////////////
    // programming stage

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            prog_q <= PROG_IDLE;
        end else begin
            case (prog_q)
                PROG_IDLE: begin
                    // a load while busy is dropped; upstream waits
                    if (tr_load_valid) begin
                        prog_q <= PROG_BUSY;
                    end
                end
                PROG_BUSY: begin
                    if (move) begin
                        prog_q <= PROG_IDLE;
                    end
                end
                default: prog_q <= PROG_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            prog_data_q <= '0;
        end else if (tr_load_valid && (prog_q == PROG_IDLE)) begin
            prog_data_q <= tr_load_data;
        end
    end

    // next-state copy so the pin flop matches the state exactly
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            program_stage_busy <= 1'b0;
        end else if (prog_q == PROG_IDLE) begin
            program_stage_busy <= tr_load_valid;
        end else begin
            program_stage_busy <= !move;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // source stage

    trst_src_stage u_src (
        .clk(clk),
        .reset(reset),
        .load(move),
        .load_data(prog_data_q),
        .done(src_done),
        .active(source_stage_active),
        .data(src_tr_data)
    );

    ////////////////////////////////////////////////////////////////////
    // outstanding write status

    // saturates rather than wraps; 15 in flight is far beyond need
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wack_q <= WACK_ZERO;
        end else if (wr_cmd_issue && !wr_status_ret) begin
            if (wack_q != WACK_MAX) begin
                wack_q <= wack_q + WACK_ONE;
            end
        end else if (wr_status_ret && !wr_cmd_issue) begin
            if (wack_q != WACK_ZERO) begin
                wack_q <= wack_q - WACK_ONE;
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            write_ack_pending <= 1'b0;
        end else if (wr_cmd_issue) begin
            write_ack_pending <= 1'b1;
        end else if (wr_status_ret) begin
            write_ack_pending <= (wack_q > WACK_ONE);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // register words

    always_comb begin
        status_word = '0;
        status_word[PROG_BIT] = program_stage_busy;
        status_word[SRC_BIT] = source_stage_active;
        status_word[WACK_BIT] = write_ack_pending;
        status_word[OCC_MSB:OCC_LSB] = dest_fifo_occupancy;
        status_word[HEAD_MSB:HEAD_LSB] = rd_ptr_q;
    end

    always_comb begin
        config_word = '0;
        config_word[DEPTH_MSB:DEPTH_LSB] = DEST_DEPTH_CFG;
    end

    always_comb begin
        control_word = '0;
        control_word[HOLD_BIT] = hold_q;
    end

    ////////////////////////////////////////////////////////////////////
    // apb slave, one wait state

    assign access = apb_req.psel && apb_req.penable;
    assign done_edge = access && apb_rsp.pready;
    assign mapped = (apb_req.paddr == STATUS_OFF)
        || (apb_req.paddr == CONFIG_OFF)
        || (apb_req.paddr == CONTROL_OFF);

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            apb_rsp <= '0;
        end else if (access && !apb_rsp.pready) begin
            apb_rsp.pready <= 1'b1;
            apb_rsp.pslverr <= !mapped;
            case (apb_req.paddr)
                STATUS_OFF: apb_rsp.prdata <= status_word;
                CONFIG_OFF: apb_rsp.prdata <= config_word;
                CONTROL_OFF: apb_rsp.prdata <= control_word;
                default: apb_rsp.prdata <= '0;
            endcase
        end else begin
            apb_rsp.pready <= 1'b0;
            apb_rsp.pslverr <= 1'b0;
        end
    end

    // writes to the read-only words are quietly dropped
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            hold_q <= 1'b0;
        end else if (done_edge && apb_req.pwrite
            && (apb_req.paddr == CONTROL_OFF)) begin
            hold_q <= apb_req.pwdata[HOLD_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    occ_range_a: assert property (occ_q <= OCC_FOUR)
        else $error("occupancy beyond four");

    full_code_a: assert property (fifo_full == (occ_q == OCC_FOUR))
        else $error("full does not match occupancy four");

    empty_move_a: assert property (
        (prog_q == PROG_BUSY) && fifo_empty && !hold_q
        |=> !program_stage_busy && (dest_fifo_occupancy == OCC_ONE))
        else $error("request did not enter empty fifo");

    part_wait_a: assert property (
        program_stage_busy && !fifo_empty && source_stage_active
        && !src_done |=> program_stage_busy)
        else $error("request moved while source busy");

    full_block_a: assert property (
        fifo_full && !dst_done |=> $stable(occ_q) && $stable(wr_ptr_q))
        else $error("full fifo accepted a request");

    full_leave_a: assert property (
        fifo_full && dst_done |=> (occ_q == OCC_FOUR - OCC_ONE))
        else $error("head completion did not free an entry");

    wack_bit_a: assert property (
        ##1 write_ack_pending == ($past(wr_cmd_issue)
        || ($past(wack_q) > ($past(wr_status_ret) ? WACK_ONE : WACK_ZERO))))
        else $error("write status bit wrong");

    src_bit_a: assert property (
        move |=> source_stage_active && (src_tr_data == $past(prog_data_q)))
        else $error("source stage not busy after hand-over");

    src_keep_a: assert property (
        src_done && !move |=> !source_stage_active ##0 $stable(src_tr_data))
        else $error("source contents lost on idle");

    prog_load_a: assert property (
        tr_load_valid && !program_stage_busy |=> program_stage_busy
        && (prog_data_q == $past(tr_load_data)))
        else $error("programming stage did not take request");

    // a load offered while busy must leave the held request untouched
    load_drop_a: assert property (
        tr_load_valid && program_stage_busy |=> $stable(prog_data_q))
        else $error("busy stage took a new request");

    occ_read_a: assert property (
        access && !apb_rsp.pready && (apb_req.paddr == STATUS_OFF)
        |=> apb_rsp.pready
        && (apb_rsp.prdata[OCC_MSB:OCC_LSB] == $past(dest_fifo_occupancy)))
        else $error("occupancy field misread");

    depth_read_a: assert property (
        access && !apb_rsp.pready && (apb_req.paddr == CONFIG_OFF)
        |=> apb_rsp.prdata[DEPTH_MSB:DEPTH_LSB] == DEPTH_CODE_4)
        else $error("depth code misread");

    busy_clear_a: assert property (
        move |=> !program_stage_busy ##1 !program_stage_busy
        || $past(tr_load_valid))
        else $error("busy did not clear on hand-over");

endmodule

`default_nettype wire

// ---- trst_upstream_model.sv ----
// upstream controller model: hands transfer requests to the tracker.
// assumes the tracker clock; waits for an idle programming stage unless rude is set.
`timescale 1ns/1ps
`default_nettype none

module trst_upstream_model (
    input wire logic clk,
    input wire logic reset,
    input wire logic go,
    input wire logic rude,
    input wire logic [trst_pkg::TR_W-1:0] word,
    input wire logic busy,
    output logic tr_load_valid,
    output logic [trst_pkg::TR_W-1:0] tr_load_data
);
    import trst_pkg::*;
    logic pend_q;
    logic [TR_W-1:0] word_q;
    ////////////////////////////////////////
    // rude ignores busy, only for the refusal scenario
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pend_q <= 1'b0;
            word_q <= '0;
            tr_load_valid <= 1'b0;
            tr_load_data <= '0;
        end else if (go) begin
            pend_q <= 1'b1;
            word_q <= word;
        end else if (pend_q && !tr_load_valid && (!busy || rude)) begin
            pend_q <= 1'b0;
            tr_load_valid <= 1'b1;
            tr_load_data <= word_q;
        end else begin
            tr_load_valid <= 1'b0;
            // data toggles when idle so a stale word is never reused
            tr_load_data <= ~tr_load_data;
        end
    end
endmodule

`default_nettype wire

// ---- trst_tracker_tb.sv ----
// self-checking bench for the transfer request stage tracker.
// assumes the upstream model file; apb master and pulses from here.
`timescale 1ns/1ps
`default_nettype none

module trst_tracker_tb;
    import trst_pkg::*;
    logic clk, reset, go, rude, src_done, dst_done;
    logic wr_cmd_issue, wr_status_ret, tr_load_valid, err;
    logic program_stage_busy, source_stage_active;
    logic write_ack_pending, dest_head_valid;
    trst_apb_req_type apb_req;
    trst_apb_rsp_type apb_rsp;
    logic [TR_W-1:0] word, tr_load_data, src_tr_data, dest_head_data;
    logic [DATA_W-1:0] rd;
    logic [TR_W-1:0] w [4];
    logic [OCC_W-1:0] dest_fifo_occupancy;
    int n_errors, n_tests, seed, k, n, r;

    trst_tracker u_trst_tracker (.clk(clk), .reset(reset),
        .apb_req(apb_req), .apb_rsp(apb_rsp),
        .tr_load_valid(tr_load_valid), .tr_load_data(tr_load_data),
        .src_done(src_done), .dst_done(dst_done),
        .wr_cmd_issue(wr_cmd_issue), .wr_status_ret(wr_status_ret),
        .program_stage_busy(program_stage_busy),
        .source_stage_active(source_stage_active),
        .write_ack_pending(write_ack_pending),
        .dest_fifo_occupancy(dest_fifo_occupancy),
        .src_tr_data(src_tr_data), .dest_head_data(dest_head_data),
        .dest_head_valid(dest_head_valid));

    trst_upstream_model u_trst_upstream_model (.clk(clk), .reset(reset),
        .go(go), .rude(rude), .word(word), .busy(program_stage_busy),
        .tr_load_valid(tr_load_valid), .tr_load_data(tr_load_data));

    ////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic tally_and_finish;
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    function automatic logic [31:0] st(input logic [2:0] o,
        input logic wa, input logic sa, input logic pb);
        return {25'h0, o, 1'b0, wa, sa, pb};
    endfunction

    task automatic tick(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask

    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a,
        input logic [31:0] d);
        int t;
        @(posedge clk);
        apb_req <= '{1'b1, 1'b0, wr, a, d};
        @(posedge clk);
        apb_req.penable <= 1'b1;
        t = 0;
        do begin
            @(posedge clk);
            t++;
        end while (apb_rsp.pready !== 1'b1 && t < 50);
        rd = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        apb_req <= '0;
        if (t >= 50) n_errors++;
    endtask

    // 0 src_done, 1 dst_done, 2 write issue, 3 write status
    task automatic pulse(input int s);
        @(posedge clk);
        case (s)
            0: src_done <= 1'b1;
            1: dst_done <= 1'b1;
            2: wr_cmd_issue <= 1'b1;
            default: wr_status_ret <= 1'b1;
        endcase
        @(posedge clk);
        {src_done, dst_done, wr_cmd_issue, wr_status_ret} <= 4'h0;
        #1;
    endtask

    task automatic load(input logic [31:0] d, input logic bad);
        int t;
        @(posedge clk);
        go <= 1'b1;
        rude <= bad;
        word <= d;
        @(posedge clk);
        go <= 1'b0;
        word <= ~d;
        t = 0;
        do begin
            tick(1);
            t++;
        end while (program_stage_busy !== 1'b1 && t < 20);
    endtask

    task automatic idle_chk;
        chk(32'({program_stage_busy, source_stage_active,
            write_ack_pending, dest_fifo_occupancy, dest_head_valid}), 0);
    endtask

    ////////////////////////////////////////
    initial begin
        #(25 * 20000);
        n_errors++;
        tally_and_finish;
    end

    initial begin
        seed = 32'hc9ad;
        n_errors = 0;
        n_tests = 0;
        reset = 1'b1;
        apb_req = '0;
        {go, rude, src_done, dst_done, wr_cmd_issue, wr_status_ret} = '0;
        word = '0;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        tick(1);
        idle_chk;
        apb(1'b1, STATUS_OFF, 32'hffffffff);
        apb(1'b0, STATUS_OFF, 32'h0);
        chk(rd & 32'h77, 32'h0);
        apb(1'b1, CONFIG_OFF, 32'h0);
        apb(1'b0, CONFIG_OFF, 32'h0);
        chk(32'(rd[9:8]), 32'h2);
        apb(1'b0, CONTROL_OFF, 32'h0);
        chk(32'(rd[0]), 32'h0);
        apb(1'b0, 12'hff0, 32'h0);
        chk({rd[30:0], err}, 32'h1);
        for (k = 0; k < 4; k++) begin
            w[k] = $random(seed);
            load(w[k], 1'b0);
            chk(32'(program_stage_busy), 1);
            if (k > 0) begin
                tick(3);
                chk(32'(program_stage_busy), 1);
                chk(32'(dest_fifo_occupancy), k);
                pulse(0);
                chk(32'(program_stage_busy), 1);
            end
            tick(1);
            chk(32'(program_stage_busy), 0);
            chk(32'(dest_fifo_occupancy), k + 1);
            chk(32'(source_stage_active), 1);
            chk(src_tr_data, w[k]);
        end
        pulse(0);
        chk(32'(source_stage_active), 0);
        chk(src_tr_data, w[3]);
        apb(1'b0, STATUS_OFF, 32'h0);
        chk(rd & 32'h77, st(3'h4, 1'b0, 1'b0, 1'b0));
        chk(dest_head_data, w[0]);
        w[0] = $random(seed);
        load(w[0], 1'b0);
        tick(4);
        chk(32'(program_stage_busy), 1);
        chk(32'(dest_fifo_occupancy), 4);
        load(~w[0], 1'b1);
        tick(3);
        chk(32'({program_stage_busy, dest_fifo_occupancy}), 32'hc);
        pulse(1);
        chk(32'(dest_fifo_occupancy), 3);
        chk(dest_head_data, w[1]);
        tick(1);
        chk(32'(dest_fifo_occupancy), 4);
        chk(32'(program_stage_busy), 0);
        chk(src_tr_data, w[0]);
        pulse(0);
        for (k = 0; k < 4; k++) begin
            chk(dest_head_data, w[(k + 1) % 4]);
            pulse(1);
            chk(32'(dest_fifo_occupancy), 3 - k);
        end
        chk(32'(dest_head_valid), 0);
        for (r = 0; r < 3; r++) begin
            n = 1 + ({$random(seed)} % 6);
            for (k = 0; k < n; k++) pulse(2);
            apb(1'b0, STATUS_OFF, 32'h0);
            chk(rd & 32'h77, st(3'h0, 1'b1, 1'b0, 1'b0));
            for (k = 0; k < n; k++) begin
                chk(32'(write_ack_pending), 1);
                pulse(3);
            end
            chk(32'(write_ack_pending), 0);
        end
        apb(1'b1, CONTROL_OFF, 32'h1);
        load($random(seed), 1'b0);
        tick(3);
        chk(32'({program_stage_busy, dest_fifo_occupancy}), 32'h8);
        apb(1'b1, CONTROL_OFF, 32'h0);
        tick(1);
        chk(32'({program_stage_busy, dest_fifo_occupancy}), 32'h1);
        // second reset with a request in flight
        @(posedge clk);
        reset <= 1'b1;
        @(posedge clk);
        reset <= 1'b0;
        tick(1);
        idle_chk;
        tally_and_finish;
    end
endmodule

`default_nettype wire
